// ==== sync_burst_sram_port.sv ====
// Synchronous burst memory port with a Wishbone mode/status window
// What this block does
// - Sync inputs sampled only at rising edge
// - Output enable and sleep are asynchronous
// - Either address strobe starts burst, loads address
// - Two-bit counter steps only when enabled
// - Order select picks linear or interleaved
// - New address accepted every cycle
// - Flow-through: data right after sampling edge
// - Pipelined: output register adds one clock
// - Dual deselect: pipelined outputs off after second edge, flow-through after capture
// - Single deselect: outputs off after capture
// - Mode register bit chooses single or dual deselect
// - Byte gate plus lane enables writes lanes
// - Global write writes all lanes
// - Defaults: single deselect, interleaved, pipelined
// - Writes self-timed in one sampled cycle
// - Low address bits preset the counter
// - Sleep request high enters sleep
module sync_burst_sram_port
   import sram_port_pkg::*;
#(
   parameter int ADDR_W = ADDR_W_DEF,
   parameter int LANES  = LANES_DEF,
   parameter int LANE_W = LANE_W_DEF
) (
   input  wire logic                    MCLK,
   input  wire logic                    RST_B,
   input  wire logic [ADDR_W-1:0]       ADDR,
   input  wire logic [LANES*LANE_W-1:0] DQ_I,
   output logic      [LANES*LANE_W-1:0] DQ_O,
   output logic                         DQ_OE,
   input  wire logic                    CHIP_SELECT_N,
   input  wire logic                    PROCESSOR_ADDR_STROBE_N,
   input  wire logic                    CONTROLLER_ADDR_STROBE_N,
   input  wire logic                    BURST_STEP_ENABLE_N,
   input  wire logic                    BYTE_WRITE_GATE_N,
   input  wire logic [LANES-1:0]        LANE_WRITE_ENABLE_N,
   input  wire logic                    GLOBAL_WRITE_ALL_N,
   input  wire logic                    OUTPUT_ENABLE_N,
   input  wire logic                    SLEEP_REQUEST,
   input  wire logic                    WB_CYC_I,
   input  wire logic                    WB_STB_I,
   input  wire logic                    WB_WE_I,
   input  wire logic [WB_ADR_W-1:0]     WB_ADR_I,
   input  wire logic [3:0]              WB_SEL_I,
   input  wire logic [WB_DAT_W-1:0]     WB_DAT_I,
   output logic      [WB_DAT_W-1:0]     WB_DAT_O,
   output logic                         WB_ACK_O
);
   localparam int DW = LANES * LANE_W;

   logic [DW-1:0]        mem_r [2**ADDR_W];
   logic [2:0]           cfg_r;
   logic [1:0]           async_s;
   logic                 oe_n_s;
   logic                 sleep_s;
   logic                 active;
   logic                 load;
   logic                 access;
   logic                 wr;
   logic                 rd;
   logic                 desel;
   logic                 sel_r;
   logic [ADDR_W-3:0]    hi_r;
   logic [BURST_W-1:0]   acc_off;
   logic [ADDR_W-1:0]    acc_addr;
   logic [LANES-1:0]     lanes;
   logic [DW-1:0]        rd_word;
   logic [DW-1:0]        pipe_r;
   logic                 rd1_r;
   logic                 data_pend;
   logic                 drive_nxt;
   logic                 pipe_mode;
   logic                 interleave;
   logic                 dual_mode;
   logic                 wb_req;
   logic [WB_DAT_W-1:0]  rdata_nxt;

   // Lanes written by a command: global overrides the byte gate
   function automatic logic [LANES-1:0] wr_lanes(input logic gw_n, input logic bg_n,
                                                  input logic [LANES-1:0] le_n);
      if (!gw_n) begin
         wr_lanes = '1;
      end else if (!bg_n) begin
         wr_lanes = ~le_n;
      end else begin
         wr_lanes = '0;
      end
   endfunction

   assign pipe_mode  = cfg_r[CFG_PIPE_BIT];
   assign interleave = cfg_r[CFG_ORDER_BIT];
   assign dual_mode  = cfg_r[CFG_DUAL_BIT];

   // Output enable and sleep arrive without reference to the clock
   pin_sync #(.W(2)) u_async_sync (
      .clk   (MCLK),
      .rst_b (RST_B),
      .d     ({SLEEP_REQUEST, OUTPUT_ENABLE_N}),
      .q     (async_s)
   );
   assign oe_n_s  = async_s[0];
   assign sleep_s = async_s[1];
   assign active  = !sleep_s;

   // Command decode on the sampled synchronous inputs
   always_comb begin
      load   = active && (!PROCESSOR_ADDR_STROBE_N || !CONTROLLER_ADDR_STROBE_N);
      access = active && (load ? !CHIP_SELECT_N : sel_r);
      lanes  = wr_lanes(GLOBAL_WRITE_ALL_N, BYTE_WRITE_GATE_N, LANE_WRITE_ENABLE_N);
      // A processor-strobe load always starts as a read
      wr     = access && !(load && !PROCESSOR_ADDR_STROBE_N) && (lanes != '0);
      rd     = access && !wr;
      desel  = load && CHIP_SELECT_N;
   end

   burst_addr_gen u_burst (
      .clk        (MCLK),
      .rst_b      (RST_B),
      .load       (load),
      .start      (ADDR[BURST_W-1:0]),
      .step_n     (BURST_STEP_ENABLE_N),
      .interleave (interleave),
      .hold       (!active),
      .offset     (acc_off)
   );

   assign acc_addr = {(load ? ADDR[ADDR_W-1:BURST_W] : hi_r), acc_off};
   assign rd_word  = mem_r[acc_addr];

   always_ff @(posedge MCLK) begin
      if (!RST_B) begin
         sel_r <= 1'b0;
         hi_r  <= '0;
      end else if (load) begin
         sel_r <= !CHIP_SELECT_N;
         hi_r  <= ADDR[ADDR_W-1:BURST_W];
      end
   end

   // Array write completes at the sampling edge, no extra strobes
   for (genvar g = 0; g < LANES; g++) begin : g_lane
      always_ff @(posedge MCLK) begin
         if (wr && lanes[g]) begin
            mem_r[acc_addr][g*LANE_W +: LANE_W] <= DQ_I[g*LANE_W +: LANE_W];
         end
      end
   end

   // Read pipeline: one stage for flow-through, two for pipelined
   always_ff @(posedge MCLK) begin
      if (!RST_B) begin
         rd1_r  <= 1'b0;
         pipe_r <= '0;
      end else begin
         rd1_r  <= rd;
         pipe_r <= rd_word;
      end
   end

   assign data_pend = pipe_mode ? rd1_r : rd;
   // Single deselect cuts a pending read at once; dual lets it finish
   assign drive_nxt = data_pend && !(!dual_mode && desel)
                      && active && !oe_n_s;

   always_ff @(posedge MCLK) begin
      if (!RST_B) begin
         DQ_O  <= '0;
         DQ_OE <= 1'b0;
      end else begin
         if (data_pend) begin
            DQ_O <= pipe_mode ? pipe_r : rd_word;
         end
         DQ_OE <= drive_nxt;
      end
   end

   // Wishbone slave: mode register and status register
   assign wb_req = WB_CYC_I && WB_STB_I;

   always_comb begin
      rdata_nxt = '0;
      case (WB_ADR_I)
         CFG_OFS: begin
            rdata_nxt[2:0] = cfg_r;
         end
         STAT_OFS: begin
            rdata_nxt[STAT_SLEEP_BIT]                       = sleep_s;
            rdata_nxt[STAT_SEL_BIT]                         = sel_r;
            rdata_nxt[STAT_DRIVE_BIT]                       = DQ_OE;
            rdata_nxt[STAT_PEND_BIT]                        = rd1_r;
            rdata_nxt[STAT_OFF_LSB +: BURST_W]              = acc_off;
         end
         default: begin
            rdata_nxt = '0;
         end
      endcase
   end

   always_ff @(posedge MCLK) begin
      if (!RST_B) begin
         WB_ACK_O <= 1'b0;
         WB_DAT_O <= '0;
      end else begin
         WB_ACK_O <= wb_req && !WB_ACK_O;
         WB_DAT_O <= (wb_req && !WB_ACK_O) ? rdata_nxt : '0;
      end
   end

   always_ff @(posedge MCLK) begin
      if (!RST_B) begin
         cfg_r <= CFG_RESET;
      end else if (wb_req && WB_ACK_O && WB_WE_I && WB_SEL_I[0]
                   && WB_ADR_I == CFG_OFS) begin
         cfg_r <= WB_DAT_I[2:0];
      end
   end

   // Checks
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RST_B);

   sequence rd_pipe_s;
      rd && pipe_mode ##1 pipe_mode;
   endsequence

   sequence rd_then_desel_s;
      rd && pipe_mode && !oe_n_s && active
      ##1 desel && dual_mode && pipe_mode && !oe_n_s && active;
   endsequence

   wb_ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O)
      else $error("ack stayed high two cycles");
   burst_load_a: assert property (load && !CHIP_SELECT_N |-> acc_addr == ADDR)
      else $error("load did not use the presented address");
   burst_hold_a: assert property (!load && BURST_STEP_ENABLE_N && active && $past(active)
                                  && $stable(interleave) |-> acc_off == $past(acc_off))
      else $error("burst offset moved without step");
   burst_linear_a: assert property (!load && !BURST_STEP_ENABLE_N && !interleave
                                    && $past(!interleave) && active && $past(active)
                                    |-> acc_off == 2'($past(acc_off) + BURST_ONE))
      else $error("linear burst did not advance by one");
   flow_latency_a: assert property (rd && !pipe_mode |=> DQ_O == $past(rd_word))
      else $error("flow-through data late");
   pipe_latency_a: assert property (rd_pipe_s |=> DQ_O == $past(rd_word, 2))
      else $error("pipelined data not two edges after read");
   single_desel_a: assert property (desel && !dual_mode |=> !DQ_OE)
      else $error("single deselect left outputs on");
   dual_desel_a: assert property (rd_then_desel_s |=> DQ_OE ##1 !DQ_OE)
      else $error("dual deselect timing wrong");
   global_write_a: assert property (wr && !GLOBAL_WRITE_ALL_N
                                    |=> mem_r[$past(acc_addr)] == $past(DQ_I))
      else $error("global write missed a lane");
   lane_keep_a: assert property (wr && GLOBAL_WRITE_ALL_N && LANE_WRITE_ENABLE_N[0]
                                 |=> mem_r[$past(acc_addr)][LANE_W-1:0]
                                     == $past(rd_word[LANE_W-1:0]))
      else $error("disabled lane was written");
   sleep_quiet_a: assert property (sleep_s |=> !DQ_OE)
      else $error("outputs driven in sleep");
   oe_gate_a: assert property (oe_n_s |=> !DQ_OE)
      else $error("outputs driven without enable");
endmodule

// ==== sram_port_pkg.sv ====
// Shared constants for the synchronous burst memory port
package sram_port_pkg;
   localparam int          ADDR_W_DEF     = 8;
   localparam int          LANES_DEF      = 4;
   localparam int          LANE_W_DEF     = 9;
   localparam int          WB_ADR_W       = 4;
   localparam int          WB_DAT_W       = 32;
   localparam int          BURST_W        = 2;
   localparam logic [3:0]  CFG_OFS        = 4'h0;
   localparam logic [3:0]  STAT_OFS       = 4'h4;
   localparam int          CFG_PIPE_BIT   = 0;
   localparam int          CFG_ORDER_BIT  = 1;
   localparam int          CFG_DUAL_BIT   = 2;
   localparam logic [2:0]  CFG_RESET      = 3'h3;
   localparam int          STAT_SLEEP_BIT = 0;
   localparam int          STAT_SEL_BIT   = 1;
   localparam int          STAT_DRIVE_BIT = 2;
   localparam int          STAT_PEND_BIT  = 3;
   localparam int          STAT_OFF_LSB   = 4;
   localparam logic [1:0]  BURST_ZERO     = 2'h0;
   localparam logic [1:0]  BURST_ONE      = 2'h1;
endpackage

// ==== pin_sync.sv ====
// Two-flop synchroniser for asynchronous pin levels
module pin_sync #(
   parameter int W = 2
) (
   input  wire logic         clk,
   input  wire logic         rst_b,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_r;

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         meta_r <= '0;
         q      <= '0;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule

// ==== burst_addr_gen.sv ====
// Two-bit burst offset generator, linear or interleaved
module burst_addr_gen
   import sram_port_pkg::*;
(
   input  wire logic               clk,
   input  wire logic               rst_b,
   input  wire logic               load,
   input  wire logic [BURST_W-1:0] start,
   input  wire logic               step_n,
   input  wire logic               interleave,
   input  wire logic               hold,
   output logic      [BURST_W-1:0] offset
);
   logic [BURST_W-1:0] start_r;
   logic [BURST_W-1:0] step_r;
   logic [BURST_W-1:0] start_use;
   logic [BURST_W-1:0] step_use;

   always_comb begin
      start_use = load ? start : start_r;
      step_use  = load ? BURST_ZERO
                       : (step_n ? step_r : step_r + BURST_ONE);
      offset    = interleave ? (start_use ^ step_use)
                             : (start_use + step_use);
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         start_r <= BURST_ZERO;
         step_r  <= BURST_ZERO;
      end else if (!hold) begin
         start_r <= start_use;
         step_r  <= step_use;
      end
   end
endmodule

// ==== ctl_model.sv ====
// Controller model driving the synchronous pins of the burst port
module ctl_model (
   input  wire logic        clk,
   output logic      [7:0]  a      = 8'h00,
   output logic      [35:0] d      = 36'h0_0000_0000,
   output logic             sel_n  = 1'h1,
   output logic             pas_n  = 1'h1,
   output logic             cas_n  = 1'h1,
   output logic             step_n = 1'h1,
   output logic             gw_n   = 1'h1,
   output logic             bw_n   = 1'h1,
   output logic      [3:0]  le_n   = 4'hF
);
   // One command per call, launched just after a rising edge
   task automatic put(input logic p, c, s, st, g, b, input logic [3:0] le,
                      input logic [7:0] ad, input logic [35:0] wd);
      @(posedge clk);
      pas_n <= p;
      cas_n <= c;
      sel_n <= s;
      step_n <= st;
      gw_n <= g;
      bw_n <= b;
      le_n <= le;
      a <= ad;
      // Cycles that write no lane show the inverse of the last value on all data lines
      d <= (!g || (!b && !(&le))) ? wd : ~d;
   endtask
   task automatic idle(input logic st);
      put(1'h1, 1'h1, 1'h1, st, 1'h1, 1'h1, 4'hF, a, 36'h0_0000_0000);
   endtask
endmodule

// ==== tb_sync_burst_sram_port.sv ====
// Self-checking bench for the synchronous burst memory port
module tb_sync_burst_sram_port
   import sram_port_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [35:0] D1  = 36'h1_2345_6789;
   localparam logic [35:0] D2  = 36'hA_BCDE_F012;
   localparam logic [35:0] LN1 = 36'h0_0003_FE00;
   localparam logic [35:0] MIX = (D1 & ~LN1) | (D2 & LN1);
   logic        mclk  = 1'h0;
   logic        rst_b = 1'h0;
   logic        oe_n  = 1'h0;
   logic        sleep = 1'h0;
   logic        req   = 1'h0;
   logic        we    = 1'h0;
   logic [3:0]  adr   = 4'h0;
   logic [3:0]  sel   = 4'hF;
   logic [31:0] wdat  = 32'h0000_0000;
   logic [31:0] rdat;
   logic [31:0] wb_dat;
   logic        wb_ack;
   logic [35:0] dq_o;
   logic        dq_oe;
   logic [7:0]  a;
   logic [35:0] d;
   logic        sel_n;
   logic        pas_n;
   logic        cas_n;
   logic        step_n;
   logic        gw_n;
   logic        bw_n;
   logic [3:0]  le_n;
   int          n_fail = 0;
   int          n_compared = 0;

   ctl_model ctl_model_i (.clk(mclk), .a(a), .d(d), .sel_n(sel_n), .pas_n(pas_n),
      .cas_n(cas_n), .step_n(step_n), .gw_n(gw_n), .bw_n(bw_n), .le_n(le_n));
   sync_burst_sram_port sync_burst_sram_port_i (.MCLK(mclk), .RST_B(rst_b), .ADDR(a),
      .DQ_I(d), .DQ_O(dq_o), .DQ_OE(dq_oe), .CHIP_SELECT_N(sel_n),
      .PROCESSOR_ADDR_STROBE_N(pas_n), .CONTROLLER_ADDR_STROBE_N(cas_n),
      .BURST_STEP_ENABLE_N(step_n), .BYTE_WRITE_GATE_N(bw_n), .LANE_WRITE_ENABLE_N(le_n),
      .GLOBAL_WRITE_ALL_N(gw_n), .OUTPUT_ENABLE_N(oe_n), .SLEEP_REQUEST(sleep),
      .WB_CYC_I(req), .WB_STB_I(req), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
      .WB_DAT_I(wdat), .WB_DAT_O(wb_dat), .WB_ACK_O(wb_ack));

   initial begin
      forever #2 mclk = ~mclk;
   end
   task automatic chk(input string what, input logic [35:0] exp, got);
      n_compared++;
      if (got !== exp) begin
         $display("BAD %s exp %h got %h", what, exp, got);
         n_fail++;
      end
   endtask
   task automatic wb(input logic w, input logic [3:0] ad, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge mclk);
      req <= 1'h1;
      we <= w;
      adr <= ad;
      wdat <= wd;
      do begin
         @(posedge mclk);
         n++;
      end while (wb_ack !== 1'h1 && n < 50);
      rdat = wb_dat;
      if (n >= 50) n_fail++;
      req <= 1'h0;
   endtask
   task automatic cfg(input logic [2:0] v);
      wb(1'h1, CFG_OFS, 32'(v));
   endtask
   task automatic load(input logic p, s, input logic [7:0] ad);
      ctl_model_i.put(p, !p, s, 1'h1, 1'h1, 1'h1, 4'hF, ad, 36'h0_0000_0000);
   endtask
   task automatic rd(input logic p, input logic [7:0] ad, input int lat, input logic [35:0] e);
      load(p, 1'h0, ad);
      repeat (lat) ctl_model_i.idle(1'h1);
      #1;
      chk("read data", e, dq_o);
   endtask
   task automatic wr(input logic g, input logic [3:0] le, input logic [7:0] ad,
                     input logic [35:0] wd);
      ctl_model_i.put(1'h1, 1'h0, 1'h0, 1'h1, g, !g, le, ad, wd);
      ctl_model_i.idle(1'h1);
   endtask
   task automatic t_reset();
      wb(1'h1, 4'hC, 32'hFFFF_FFFF);
      wb(1'h0, 4'hC, 32'h0000_0000);
      chk("unmapped read", 36'h0_0000_0000, 36'(rdat));
      // Mode write without lane 0 select must be ignored
      sel <= 4'hE;
      wb(1'h1, CFG_OFS, 32'h0000_0000);
      sel <= 4'hF;
      wb(1'h0, CFG_OFS, 32'h0000_0000);
      chk("mode reset", 36'(CFG_RESET), 36'(rdat[2:0]));
   endtask
   task automatic t_write();
      wr(1'h0, 4'hF, 8'h10, D1);
      wr(1'h1, 4'hD, 8'h10, D2);
      rd(1'h0, 8'h10, 2, MIX);
      ctl_model_i.idle(1'h1);
      #1;
      chk("held word", MIX, dq_o);
      rd(1'h1, 8'h10, 2, MIX);
   endtask
   task automatic t_burst(input logic inter);
      int i;
      cfg({1'h0, inter, 1'h1});
      for (i = 0; i < 4; i++) begin
         ctl_model_i.put(1'h1, 1'h0, 1'h0, 1'h1, 1'h0, 1'h1, 4'hF, 8'h20 + 8'(i),
            36'h0_0000_0A00 + 36'(i));
      end
      ctl_model_i.idle(1'h1);
      load(1'h0, 1'h0, 8'h21);
      ctl_model_i.idle(1'h0);
      for (i = 0; i < 4; i++) begin
         ctl_model_i.idle(1'h0);
         #1;
         chk("burst word", 36'h0_0000_0A00 + 36'(inter ? (1 ^ i) : ((1 + i) % 4)), dq_o);
      end
      ctl_model_i.idle(1'h1);
   endtask
   task automatic t_desel(input logic dual);
      cfg({dual, 2'h3});
      load(1'h0, 1'h0, 8'h10);
      load(1'h0, 1'h1, 8'h10);
      ctl_model_i.idle(1'h1);
      #1;
      chk("drive after deselect", 36'(dual), 36'(dq_oe));
      ctl_model_i.idle(1'h1);
      #1;
      chk("drive off", 36'h0_0000_0000, 36'(dq_oe));
   endtask
   task automatic oe_probe(input logic e);
      load(1'h0, 1'h0, 8'h10);
      repeat (2) ctl_model_i.idle(1'h1);
      #1;
      chk("output drive", 36'(e), 36'(dq_oe));
   endtask
   task automatic t_sleep_oe();
      sleep <= 1'h1;
      repeat (3) ctl_model_i.idle(1'h1);
      wb(1'h0, STAT_OFS, 32'h0000_0000);
      chk("sleep flag", 36'h0_0000_0001, 36'(rdat[STAT_SLEEP_BIT]));
      wr(1'h0, 4'hF, 8'h10, 36'h0_0000_0000);
      sleep <= 1'h0;
      repeat (3) ctl_model_i.idle(1'h1);
      rd(1'h0, 8'h10, 2, MIX);
      oe_n <= 1'h1;
      repeat (4) ctl_model_i.idle(1'h1);
      oe_probe(1'h0);
      oe_n <= 1'h0;
      repeat (4) ctl_model_i.idle(1'h1);
      oe_probe(1'h1);
   endtask
   task automatic end_of_test();
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge mclk);
      rst_b <= 1'h1;
      t_reset();
      t_write();
      cfg(3'h2);
      rd(1'h0, 8'h10, 1, MIX);
      t_burst(1'h0);
      t_burst(1'h1);
      t_desel(1'h0);
      t_desel(1'h1);
      t_sleep_oe();
      end_of_test();
   end
   initial begin
      repeat (5000) @(posedge mclk);
      n_fail++;
      end_of_test();
   end
endmodule
